// file: design/osdc_device.sv
// Contract
// - colour byte 0010 carries background and rim
// - rim white only on rgb, mono rim black
// - background bits give eight rgb colours
// - mono channel background always black
// - show byte 01110 enables channels a b c
// - channel a rgb, b and c mono
// - invert byte 0011100 carries global invert
// - invert needs global and cell attribute
// - mono chars white, black when inverted
// - display-off cell never shown, not inverted; code still keys rim and background dots of a display-off cell
// - inverted blank cell is solid colour block
// - two-byte commands always sent as sixteen bits
// - position command bit layout
// - horizontal start sixteen plus twelve per step, with hpos plus one steps
// - vertical start three lines per step plus one; code steps nine lines per step when line_step_nine is set
// - write address command bit layout
// - column selects one of twenty-four; code decodes four column bits, so only columns 0 to 15
// - row selects one of twelve
// - reset and clear return address to zero
`timescale 1ns/100ps
module osdc_device
   import osdc_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   osdc_link_if.dev        link,
   input  wire logic       hsync_n,
   input  wire logic       vsync_n,
   input  wire logic       line_step_nine,
   input  wire logic       pix_fg,
   input  wire logic       pix_rim,
   input  wire logic       pix_bg_a,
   input  wire logic       pix_bg_b,
   input  wire logic       pix_bg_c,
   input  wire logic [2:0] char_rgb,
   input  wire logic       cell_invert_attr,
   input  wire logic       cell_off,
   output logic            rim_white_select,
   output logic [2:0]      bg_rgb,
   output logic            chan_a_show,
   output logic            chan_b_show,
   output logic            chan_c_show,
   output logic            global_invert_enable,
   output logic [4:0]      hpos,
   output logic [4:0]      vpos,
   output logic [4:0]      col_sel,
   output logic [4:0]      row_sel,
   output logic            addr_load,
   output logic            h_start,
   output logic            v_start,
   output logic [2:0]      out_a_rgb,
   output logic            out_a_key,
   output logic            mono_out_first,
   output logic            mono_out_first_key,
   output logic            mono_out_second,
   output logic            mono_out_second_key
);

   // -------------------------------------------------------------
   // command decode state
   // -------------------------------------------------------------
   logic       pending;
   logic [7:0] first_byte;
   logic       next_pending;
   logic [7:0] next_first_byte;
   logic       next_rim;
   logic [2:0] next_bg;
   logic [2:0] next_show;
   logic       next_invert;
   logic [4:0] next_hpos;
   logic [4:0] next_vpos;
   logic [4:0] next_col;
   logic [4:0] next_row;
   logic       next_addr_load;
   logic       take;
   logic [7:0] b;
   logic [4:0] cand_col;
   logic [4:0] cand_row;

   function automatic logic match(input logic [7:0] v, input logic [7:0] m,
                                  input logic [7:0] c);
      match = (v & m) == c;
   endfunction

   assign link.byte_ready = 1'b1;
   assign take            = link.byte_valid & link.byte_ready;
   assign b               = link.byte_data;

   always_comb begin
      next_pending    = pending;
      next_first_byte = first_byte;
      next_rim        = rim_white_select;
      next_bg         = bg_rgb;
      next_show       = {chan_a_show, chan_b_show, chan_c_show};
      next_invert     = global_invert_enable;
      next_hpos       = hpos;
      next_vpos       = vpos;
      next_col        = col_sel;
      next_row        = row_sel;
      next_addr_load  = 1'b0;
      cand_col        = {1'b0, b[ADDR_COL_LSB +: 4]};
      cand_row        = {b[ADDR_R4_BIT], first_byte[ADDR_R3_BIT],
                         b[ADDR_RLO_LSB +: 3]};
      if (take) begin
         if (pending) begin
            next_pending = 1'b0;
            if (match(first_byte, POS_MASK, POS_CODE)) begin
               next_hpos = b[POS_H_LSB +: 5];
               next_vpos = {first_byte[POS_V4_BIT], first_byte[POS_V3_BIT],
                            b[POS_VLO_LSB +: 3]};
            end else if (match(first_byte, ADDR_MASK, ADDR_CODE)) begin
               if (cand_col < COL_COUNT && cand_row < ROW_COUNT) begin
                  next_col       = cand_col;
                  next_row       = cand_row;
                  next_addr_load = 1'b1;
               end
            end
         end else if (b[TWO_BYTE_BIT]) begin
            next_pending    = 1'b1;
            next_first_byte = b;
         end else if (b == CLEAR_CODE) begin
            next_col       = RST_COL;
            next_row       = RST_ROW;
            next_addr_load = 1'b1;
         end else if (match(b, COLOR_MASK, COLOR_CODE)) begin
            next_rim = b[RIM_BIT];
            next_bg  = b[BG_LSB +: 3];
         end else if (match(b, SHOW_MASK, SHOW_CODE)) begin
            next_show = {b[SHOW_A_BIT], b[SHOW_B_BIT], b[SHOW_C_BIT]};
         end else if (match(b, INVERT_MASK, INVERT_CODE)) begin
            next_invert = b[INVERT_BIT];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pending              <= 1'b0;
         first_byte           <= 8'h00;
         rim_white_select     <= RST_RIM;
         bg_rgb               <= RST_BG;
         {chan_a_show, chan_b_show, chan_c_show} <= RST_SHOW;
         global_invert_enable <= RST_INVERT;
         hpos                 <= RST_POS;
         vpos                 <= RST_POS;
         col_sel              <= RST_COL;
         row_sel              <= RST_ROW;
         addr_load            <= 1'b0;
      end else begin
         pending              <= next_pending;
         first_byte           <= next_first_byte;
         rim_white_select     <= next_rim;
         bg_rgb               <= next_bg;
         {chan_a_show, chan_b_show, chan_c_show} <= next_show;
         global_invert_enable <= next_invert;
         hpos                 <= next_hpos;
         vpos                 <= next_vpos;
         col_sel              <= next_col;
         row_sel              <= next_row;
         addr_load            <= next_addr_load;
      end
   end

   // -------------------------------------------------------------
   // start position timing
   // -------------------------------------------------------------
   osdc_start_timer u_timer (
      .pclk           (pclk),
      .presetn        (presetn),
      .hsync_n        (hsync_n),
      .vsync_n        (vsync_n),
      .hpos           (hpos),
      .vpos           (vpos),
      .line_step_nine (line_step_nine),
      .h_start        (h_start),
      .v_start        (v_start)
   );

   // -------------------------------------------------------------
   // per-dot attribute output
   // -------------------------------------------------------------
   logic       invert;
   logic       fg_eff;
   logic [2:0] next_a_rgb;
   logic       next_a_key;
   logic [1:0] next_mono;
   logic [1:0] next_mono_key;
   logic [1:0] mono_show;
   logic [1:0] mono_bg;

   assign mono_show = {chan_c_show, chan_b_show};
   assign mono_bg   = {pix_bg_c, pix_bg_b};

   always_comb begin
      invert = global_invert_enable & cell_invert_attr;
      // blank cell has no dots, so inverting it lights the whole cell
      fg_eff = cell_off ? 1'b0 : (invert ? ~pix_fg : pix_fg);
      next_a_rgb = 3'h0;
      next_a_key = 1'b0;
      if (chan_a_show) begin
         if (fg_eff) begin
            next_a_rgb = char_rgb;
            next_a_key = 1'b1;
         end else if (pix_rim) begin
            next_a_rgb = rim_white_select ? 3'h7 : 3'h0;
            next_a_key = 1'b1;
         end else if (pix_bg_a) begin
            next_a_rgb = bg_rgb;
            next_a_key = 1'b1;
         end
      end
      for (int i = 0; i < 2; i++) begin
         next_mono[i]     = 1'b0;
         next_mono_key[i] = 1'b0;
         if (mono_show[i]) begin
            // white dot when lit, black for rim and background
            next_mono[i]     = fg_eff;
            next_mono_key[i] = fg_eff | pix_rim | mono_bg[i];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_a_rgb           <= 3'h0;
         out_a_key           <= 1'b0;
         mono_out_first      <= 1'b0;
         mono_out_first_key  <= 1'b0;
         mono_out_second     <= 1'b0;
         mono_out_second_key <= 1'b0;
      end else begin
         out_a_rgb           <= next_a_rgb;
         out_a_key           <= next_a_key;
         mono_out_first      <= next_mono[0];
         mono_out_first_key  <= next_mono_key[0];
         mono_out_second     <= next_mono[1];
         mono_out_second_key <= next_mono_key[1];
      end
   end

endmodule

// file: design/osdc_pkg.sv
package osdc_pkg;

   // -------------------------------------------------------------
   // one-byte command patterns
   // -------------------------------------------------------------
   localparam logic [7:0] CLEAR_CODE   = 8'h00;
   localparam logic [7:0] COLOR_MASK   = 8'hf0;
   localparam logic [7:0] COLOR_CODE   = 8'h20;
   localparam logic [7:0] SHOW_MASK    = 8'hf8;
   localparam logic [7:0] SHOW_CODE    = 8'h70;
   localparam logic [7:0] INVERT_MASK  = 8'hfe;
   localparam logic [7:0] INVERT_CODE  = 8'h38;

   // -------------------------------------------------------------
   // two-byte command first-byte patterns
   // -------------------------------------------------------------
   localparam int         TWO_BYTE_BIT = 7;
   localparam logic [7:0] POS_MASK     = 8'hfc;
   localparam logic [7:0] POS_CODE     = 8'h80;
   localparam logic [7:0] ADDR_MASK    = 8'hfe;
   localparam logic [7:0] ADDR_CODE    = 8'h88;

   // -------------------------------------------------------------
   // field positions
   // -------------------------------------------------------------
   localparam int RIM_BIT      = 0;
   localparam int BG_LSB       = 1;
   localparam int SHOW_C_BIT   = 0;
   localparam int SHOW_B_BIT   = 1;
   localparam int SHOW_A_BIT   = 2;
   localparam int INVERT_BIT   = 0;
   localparam int POS_V3_BIT   = 0;
   localparam int POS_V4_BIT   = 1;
   localparam int POS_H_LSB    = 0;
   localparam int POS_VLO_LSB  = 5;
   localparam int ADDR_R3_BIT  = 0;
   localparam int ADDR_COL_LSB = 0;
   localparam int ADDR_R4_BIT  = 4;
   localparam int ADDR_RLO_LSB = 5;

   // -------------------------------------------------------------
   // reset values
   // -------------------------------------------------------------
   localparam logic       RST_RIM    = 1'b0;
   localparam logic [2:0] RST_BG     = 3'h0;
   localparam logic [2:0] RST_SHOW   = 3'h0;
   localparam logic       RST_INVERT = 1'b0;
   localparam logic [4:0] RST_POS    = 5'h00;
   localparam logic [4:0] RST_COL    = 5'h00;
   localparam logic [4:0] RST_ROW    = 5'h00;

   // -------------------------------------------------------------
   // display geometry and start timing, in dot clocks and lines
   // -------------------------------------------------------------
   localparam logic [4:0] COL_COUNT      = 5'd24;
   localparam logic [4:0] ROW_COUNT      = 5'd12;
   localparam logic [9:0] H_BASE_CLKS    = 10'd16;
   localparam logic [9:0] H_STEP_CLKS    = 10'd12;
   localparam logic [8:0] V_STEP_LINES   = 9'd3;
   localparam logic [8:0] V_STEP_OPTION  = 9'd9;
   localparam logic [8:0] V_OFFSET_LINES = 9'd1;

   // -------------------------------------------------------------
   // host apb registers
   // -------------------------------------------------------------
   localparam logic [11:0] CMD_OFFSET    = 12'h000;
   localparam logic [11:0] STATUS_OFFSET = 12'h004;
   localparam int          CMD_TWO_BIT   = 16;
   localparam int          STAT_BUSY_BIT = 0;
   localparam int          STAT_TWO_BIT  = 1;

   typedef enum logic [1:0] {
      HS_IDLE = 2'b00,
      HS_LOW  = 2'b01,
      HS_HIGH = 2'b11
   } osdc_host_state_t;

endpackage

// file: design/osdc_link_if.sv
`timescale 1ns/100ps
interface osdc_link_if (
   input wire logic pclk
);
   logic       byte_valid;
   logic [7:0] byte_data;
   logic       byte_ready;

   modport host (
      output byte_valid,
      output byte_data,
      input  byte_ready
   );

   modport dev (
      input  byte_valid,
      input  byte_data,
      output byte_ready
   );
endinterface

// file: design/osdc_start_timer.sv
`timescale 1ns/100ps
module osdc_start_timer
   import osdc_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       hsync_n,
   input  wire logic       vsync_n,
   input  wire logic [4:0] hpos,
   input  wire logic [4:0] vpos,
   input  wire logic       line_step_nine,
   output logic            h_start,
   output logic            v_start
);

   // -------------------------------------------------------------
   // sync pin synchronisers
   // -------------------------------------------------------------
   logic [1:0] hs_meta;
   logic [1:0] hs_sync;
   logic [1:0] hs_prev;
   logic       h_rise;
   logic       v_rise;
   logic [9:0] hcnt;
   logic       hrun;
   logic [8:0] lines;
   logic       vrun;
   logic [9:0] h_target;
   logic [8:0] v_target;
   logic [9:0] next_hcnt;
   logic       next_hrun;
   logic [8:0] next_lines;
   logic       next_vrun;
   logic       next_h_start;
   logic       next_v_start;

   assign h_rise = hs_sync[0] & ~hs_prev[0];
   assign v_rise = hs_sync[1] & ~hs_prev[1];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hs_meta <= 2'b11;
         hs_sync <= 2'b11;
         hs_prev <= 2'b11;
      end else begin
         hs_meta <= {vsync_n, hsync_n};
         hs_sync <= hs_meta;
         hs_prev <= hs_sync;
      end
   end

   // -------------------------------------------------------------
   // start counters
   // -------------------------------------------------------------
   always_comb begin
      h_target = H_BASE_CLKS + 10'(H_STEP_CLKS * ({5'd0, hpos} + 10'd1));
      v_target = 9'((line_step_nine ? V_STEP_OPTION : V_STEP_LINES)
                 * {4'd0, vpos}) + V_OFFSET_LINES;
      next_hcnt    = hcnt;
      next_hrun    = hrun;
      next_lines   = lines;
      next_vrun    = vrun;
      next_h_start = 1'b0;
      next_v_start = 1'b0;
      if (h_rise) begin
         next_hcnt = 10'd1;
         next_hrun = 1'b1;
      end else if (hrun) begin
         next_hcnt = hcnt + 10'd1;
         if (hcnt == h_target) begin
            next_h_start = 1'b1;
            next_hrun    = 1'b0;
         end
      end
      if (v_rise) begin
         next_lines = 9'd0;
         next_vrun  = 1'b1;
      end else if (vrun && h_rise) begin
         next_lines = lines + 9'd1;
         if (lines + 9'd1 == v_target) begin
            next_v_start = 1'b1;
            next_vrun    = 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hcnt    <= 10'd0;
         hrun    <= 1'b0;
         lines   <= 9'd0;
         vrun    <= 1'b0;
         h_start <= 1'b0;
         v_start <= 1'b0;
      end else begin
         hcnt    <= next_hcnt;
         hrun    <= next_hrun;
         lines   <= next_lines;
         vrun    <= next_vrun;
         h_start <= next_h_start;
         v_start <= next_v_start;
      end
   end

endmodule

// file: design/osdc_host.sv
`timescale 1ns/100ps
module osdc_host
   import osdc_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   osdc_link_if.host        link
);

   // -------------------------------------------------------------
   // apb slave
   // -------------------------------------------------------------
   osdc_host_state_t state;
   osdc_host_state_t next_state;
   logic [15:0]      word;
   logic             two;
   logic [7:0]       out_byte;
   logic [15:0]      next_word;
   logic             next_two;
   logic [7:0]       next_out_byte;
   logic [31:0]      next_prdata;
   logic             mapped;
   logic             wr_cmd;
   logic             busy;

   assign busy    = state != HS_IDLE;
   assign mapped  = (paddr == CMD_OFFSET) || (paddr == STATUS_OFFSET);
   assign pready  = psel & penable;
   assign pslverr = psel & penable & ~mapped;
   assign wr_cmd  = psel & penable & pwrite & (paddr == CMD_OFFSET);

   always_comb begin
      next_prdata = prdata;
      if (psel && !penable && !pwrite) begin
         next_prdata = 32'h0;
         if (paddr == CMD_OFFSET) begin
            next_prdata[CMD_TWO_BIT:0] = {two, word};
         end else if (paddr == STATUS_OFFSET) begin
            next_prdata[STAT_BUSY_BIT] = busy;
            next_prdata[STAT_TWO_BIT]  = two;
         end
      end
   end

   // -------------------------------------------------------------
   // byte sender
   // -------------------------------------------------------------
   assign link.byte_valid = busy;
   assign link.byte_data  = out_byte;

   always_comb begin
      next_state    = state;
      next_word     = word;
      next_two      = two;
      next_out_byte = out_byte;
      case (state)
         HS_IDLE: begin
            // a new order while sending is dropped; busy shows it
            if (wr_cmd) begin
               next_word     = pwdata[15:0];
               next_two      = pwdata[CMD_TWO_BIT];
               next_out_byte = pwdata[7:0];
               next_state    = HS_LOW;
            end
         end
         HS_LOW: begin
            if (link.byte_ready) begin
               if (two) begin
                  next_out_byte = word[15:8];
                  next_state    = HS_HIGH;
               end else begin
                  next_state = HS_IDLE;
               end
            end
         end
         HS_HIGH: begin
            if (link.byte_ready) begin
               next_state = HS_IDLE;
            end
         end
         default: begin
            next_state = HS_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state    <= HS_IDLE;
         word     <= 16'h0000;
         two      <= 1'b0;
         out_byte <= 8'h00;
         prdata   <= 32'h0;
      end else begin
         state    <= next_state;
         word     <= next_word;
         two      <= next_two;
         out_byte <= next_out_byte;
         prdata   <= next_prdata;
      end
   end

endmodule

// file: verif/osdc_link_checker.sv
`timescale 1ns/100ps
module osdc_link_checker
   import osdc_pkg::*;
(
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       byte_valid,
   input wire logic [7:0] byte_data,
   input wire logic       byte_ready,
   input wire logic       rim_white_select,
   input wire logic [2:0] bg_rgb,
   input wire logic       chan_a_show,
   input wire logic       chan_b_show,
   input wire logic       chan_c_show,
   input wire logic       global_invert_enable,
   input wire logic [4:0] hpos,
   input wire logic [4:0] vpos,
   input wire logic [4:0] col_sel,
   input wire logic [4:0] row_sel,
   input wire logic       addr_load
);
   // ------------------------------------------------------------
   // first-byte tracking
   // ------------------------------------------------------------
   logic       pend, next_pend, tk, one, two, pos2, adr2;
   logic [7:0] first, next_first;
   logic [4:0] row_in;
   assign tk     = byte_valid && byte_ready;
   assign one    = tk && !pend;
   assign two    = tk && pend;
   assign pos2   = two && (first & POS_MASK) == POS_CODE;
   assign adr2   = two && (first & ADDR_MASK) == ADDR_CODE;
   assign row_in = {byte_data[ADDR_R4_BIT], first[ADDR_R3_BIT], byte_data[7:5]};
   always_comb begin
      next_pend  = tk ? (!pend && byte_data[TWO_BYTE_BIT]) : pend;
      next_first = one ? byte_data : first;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend  <= 1'b0;
         first <= 8'h00;
      end else begin
         pend  <= next_pend;
         first <= next_first;
      end
   end
   // ------------------------------------------------------------
   // link assertions
   // ------------------------------------------------------------
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_ready_tied: assert property (byte_ready)
      else $error("byte_ready dropped");
   chk_colour_load: assert property (one && (byte_data & COLOR_MASK) == COLOR_CODE |=>
      rim_white_select == $past(byte_data[RIM_BIT]) && bg_rgb == $past(byte_data[3:1]))
      else $error("colour byte not applied");
   chk_show_load: assert property (one && (byte_data & SHOW_MASK) == SHOW_CODE |=>
      {chan_a_show, chan_b_show, chan_c_show} == $past(byte_data[2:0]))
      else $error("show byte not applied");
   chk_invert_load: assert property (one && (byte_data & INVERT_MASK) == INVERT_CODE |=>
      global_invert_enable == $past(byte_data[INVERT_BIT]))
      else $error("invert byte not applied");
   chk_config_hold: assert property (!one |=> $stable({rim_white_select, bg_rgb,
      chan_a_show, chan_b_show, chan_c_show, global_invert_enable}))
      else $error("config changed");
   chk_pos_load: assert property (pos2 |=> hpos == $past(byte_data[4:0]) &&
      vpos == {$past(first[1:0]), $past(byte_data[7:5])})
      else $error("position not applied");
   chk_pos_hold: assert property (!pos2 |=> $stable({hpos, vpos}))
      else $error("position changed");
   chk_addr_load: assert property (adr2 && row_in < 5'd12 |=> addr_load &&
      row_sel == $past(row_in) && col_sel == {1'b0, $past(byte_data[3:0])})
      else $error("write address not applied");
   chk_addr_drop: assert property (adr2 && row_in > 5'd11 |=>
      !addr_load && $stable(row_sel) && $stable(col_sel))
      else $error("bad write address accepted");
   chk_clear_addr: assert property (one && byte_data == CLEAR_CODE |=>
      addr_load && row_sel == 5'h00 && col_sel == 5'h00)
      else $error("address not cleared");
endmodule

// file: verif/tb_top.sv
`timescale 1ns/100ps
module tb_top
   import osdc_pkg::*;
;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er, mono_out_second_key;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, seed;
   logic        hsync_n, vsync_n, line_step_nine, pix_fg, pix_rim, pix_bg_a, pix_bg_b;
   logic        pix_bg_c, cell_invert_attr, cell_off, rim_white_select, chan_a_show;
   logic        chan_b_show, chan_c_show, global_invert_enable, addr_load, h_start, v_start;
   logic        mono_out_first, mono_out_second, out_a_key, mono_out_first_key;
   logic [2:0]  char_rgb, bg_rgb, out_a_rgb;
   logic [4:0]  hpos, vpos, col_sel, row_sel;
   int          n_fail = 0;
   int          comparisons = 0;
   int          n;
   // ------------------------------------------------------------
   // both ends joined by the link
   // ------------------------------------------------------------
   osdc_link_if i_osdc_link_if (.pclk);
   osdc_host i_osdc_host (.link(i_osdc_link_if), .*);
   osdc_device i_osdc_device (.link(i_osdc_link_if), .*);
   osdc_link_checker i_osdc_link_checker (.byte_valid(i_osdc_link_if.byte_valid), .*,
      .byte_data(i_osdc_link_if.byte_data), .byte_ready(i_osdc_link_if.byte_ready));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      if (n_fail == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int k;
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
      if (k >= 50) begin
         n_fail++;
         complete_run();
      end
   endtask
   // command word, then poll until the link is idle again
   task automatic send(input logic [31:0] w);
      int k;
      apb(1'b1, CMD_OFFSET, w);
      k = 0;
      do begin
         apb(1'b0, STATUS_OFFSET, 32'h0);
         k++;
      end while (rd[STAT_BUSY_BIT] !== 1'b0 && k < 20);
      if (k >= 20) begin
         n_fail++;
         complete_run();
      end
   endtask
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      logic [31:0] x;
      logic [4:0]  v, h, r, er_row;
      logic [3:0]  c, er_col;
      logic [2:0]  s, ea;
      logic        lit;
      {psel, penable, pwrite, paddr, pwdata, hsync_n, vsync_n} = {47'h0, 2'b11};
      {pix_fg, pix_rim, pix_bg_a, pix_bg_b, pix_bg_c, cell_invert_attr, cell_off} = 7'h00;
      {char_rgb, line_step_nine, presetn} = 5'h00;
      seed = 32'd43689;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check({rim_white_select, bg_rgb, chan_a_show, chan_b_show, chan_c_show}, 0);
      check({global_invert_enable, col_sel, row_sel, hpos, vpos}, 0);
      for (int i = 0; i < 16; i++) begin
         send(32'h20 | i);
         check({bg_rgb, rim_white_select}, i);
         send(32'h70 | i[2:0]);
         check({chan_a_show, chan_b_show, chan_c_show}, i[2:0]);
         send(32'h38 | i[0]);
         check(global_invert_enable, i[0]);
      end
      send(32'h1f);
      check({bg_rgb, rim_white_select, global_invert_enable}, 5'h1f);
      for (int i = 0; i < 6; i++) begin
         x = xs();
         v = i == 0 ? 5'h1f : x[4:0];
         h = i == 0 ? 5'h1f : x[9:5];
         send({15'h0, 1'b1, v[2:0], h, 6'h20, v[4:3]});
         check({vpos, hpos}, {v, h});
      end
      {er_row, er_col} = 9'h0;
      for (int i = 0; i < 10; i++) begin
         x = xs();
         r = i == 0 ? 5'd11 : i == 1 ? 5'd12 : x[4:0];
         c = x[8:5];
         send({15'h0, 1'b1, r[2:0], r[4], c, 7'h44, r[3]});
         if (r < 5'd12) {er_row, er_col} = {r, c};
         check({row_sel, col_sel}, {er_row, 1'b0, er_col});
      end
      apb(1'b0, CMD_OFFSET, 32'h0);
      check(rd, {15'h0, 1'b1, r[2:0], r[4], c, 7'h44, r[3]});
      send(32'h0);
      check({row_sel, col_sel}, 0);
      apb(1'b0, 12'h008, 32'h0);
      check(rd, 32'h0);
      check(er, 1'b1);
      send(32'h27);
      for (int p = 0; p < 2; p++) begin
         s = p ? 3'h7 : 3'h5;
         send(32'h38 | p);
         send(32'h70 | s);
         for (int i = 0; i < 40; i++) begin
            x = xs();
            {pix_fg, pix_rim, pix_bg_a, pix_bg_b, pix_bg_c, cell_invert_attr, char_rgb} <= x[8:0];
            cell_off <= x[10] & x[11];
            @(posedge pclk);
            @(negedge pclk);
            lit = !cell_off && (pix_fg ^ (p[0] && cell_invert_attr));
            ea = lit ? char_rgb : pix_rim ? 3'h7 : pix_bg_a ? 3'h3 : 3'h0;
            check({out_a_rgb, mono_out_first, mono_out_second},
                  {s[2] ? ea : 3'h0, lit && s[1], lit && s[0]});
            check({out_a_key, mono_out_first_key, mono_out_second_key},
                  s & ({3{lit | pix_rim}} | {pix_bg_a, pix_bg_b, pix_bg_c}));
            @(posedge pclk);
         end
      end
      for (int i = 0; i < 2; i++) begin
         h = i ? 5'h1f : 5'h00;
         send({15'h0, 1'b1, 3'h2, h, 8'h80});
         hsync_n <= 1'b0;
         repeat (4) @(posedge pclk);
         hsync_n <= 1'b1;
         n = 0;
         do begin
            @(posedge pclk);
            n++;
            @(negedge pclk);
         end while (h_start !== 1'b1 && n < 600);
         check(n, 16 + 12 * (h + 1) + 3);
         @(posedge pclk);
      end
      for (int k = 0; k < 2; k++) begin
         line_step_nine <= k[0];
         vsync_n <= 1'b0;
         repeat (4) @(posedge pclk);
         vsync_n <= 1'b1;
         n = 0;
         for (int l = 1; l < 40 && n == 0; l++) begin
            hsync_n <= 1'b0;
            repeat (3) @(posedge pclk);
            hsync_n <= 1'b1;
            repeat (30) begin
               @(negedge pclk);
               if (v_start === 1'b1 && n == 0) n = l;
               @(posedge pclk);
            end
         end
         check(n, k ? 19 : 7);
      end
      complete_run();
   end
endmodule
